//--- src/cie_entry.sv
`timescale 1ns/10ps
`include "cie_map.svh"
module cie_entry (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Core sequencing
  input wire logic instr_boundary,
  input wire logic clear_irq_enable_instr,
  input wire logic flags_load,
  input wire logic [15:0] flags_in,
  input wire logic sw_int_req,
  input wire cie_pkg::cie_sw_e sw_int_kind,
  input wire logic [7:0] sw_int_type,
  input wire logic [15:0] cs_in,
  input wire logic [15:0] ip_in,
  input wire logic [15:0] ss_in,
  input wire logic [15:0] sp_in,
  // Results to core
  output logic entry_busy,
  output logic entry_done,
  output logic [15:0] flags_out,
  output logic [15:0] new_cs,
  output logic [15:0] new_ip,
  output logic [15:0] new_sp,
  // Pins
  input wire logic nmi_pin,
  input wire logic maskable_request_in,
  input wire logic hold_req_pin,
  input wire logic [15:0] ad_in,
  output logic irq_acknowledge_out,
  output logic ad_float,
  output logic bus_lock,
  output logic hold_ack,
  // Memory port
  output logic mem_req,
  output logic mem_we,
  output logic [19:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_done
);
  import cie_pkg::*;

  // Pin synchronisers, two stages each
  logic [10:0] sync1_reg;
  logic [10:0] sync2_reg;
  logic nmi_prev_reg; // Last synced NMI level
  logic nmi_pend_reg; // Latched NMI edge
  // Control and status registers
  logic max_mode_reg;
  logic [31:0] rdata_reg;
  // Sequencer
  cie_state_e state_reg;
  cie_state_e state_next;
  logic [6:0] cyc_reg; // Clocks since recognition
  logic [6:0] target_reg; // Last clock of this entry
  logic [7:0] vec_reg; // Selected vector type
  logic [15:0] flags_reg;
  logic [15:0] code_seg_reg;
  logic [15:0] instr_pointer_reg;
  logic [15:0] stack_ptr_reg;
  logic [15:0] ss_reg;
  logic busy_reg;
  logic done_reg;
  // Bus side outputs
  logic float_reg;
  logic lock_reg;
  logic hold_ack_reg;
  logic mem_req_reg;
  logic mem_we_reg;
  logic [19:0] mem_addr_reg;
  logic [15:0] mem_wdata_reg;
  // Acknowledge cycle engine
  cie_tstate_e ts;
  logic ack_pulse;
  logic ack_start;

  // Synced pin views
  wire nmi_sync = sync2_reg[0];
  wire irq_sync = sync2_reg[1];
  wire hold_sync = sync2_reg[2];
  wire [7:0] ad_sync = sync2_reg[10:3];

  wire nmi_rise = nmi_sync && !nmi_prev_reg;

  wire idle = (state_reg == ST_IDLE);
  wire bnd = idle && instr_boundary;
  wire take_sw = bnd && sw_int_req;
  wire take_nmi = bnd && !sw_int_req && nmi_pend_reg;
  wire take_mask = bnd && !sw_int_req && !nmi_pend_reg && irq_sync && flags_reg[`CIE_FLAG_IF_BIT];
  wire take_step = bnd && !sw_int_req && !nmi_pend_reg && !take_mask && flags_reg[`CIE_FLAG_TF_BIT];
  wire take_any = take_sw || take_nmi || take_mask || take_step;

  // Vector chosen at recognition; maskable gets its type later
  wire [7:0] sw_vec = (sw_int_kind == SW_BREAK) ? `CIE_VEC_BRK :
                      (sw_int_kind == SW_OVERFLOW) ? `CIE_VEC_OVF : sw_int_type;
  wire [7:0] take_vec = take_sw ? sw_vec : (take_nmi ? `CIE_VEC_NMI : `CIE_VEC_STEP);

  wire [6:0] sw_clk = (sw_int_kind == SW_BREAK) ? `CIE_CLK_SW_BRK :
                      (sw_int_kind == SW_OVERFLOW) ? `CIE_CLK_SW_OVF : `CIE_CLK_SW_VEC;
  wire [6:0] take_clk = take_sw ? sw_clk : take_nmi ? `CIE_CLK_NMI :
                        take_mask ? `CIE_CLK_MASKABLE : `CIE_CLK_STEP;

  // Memory operation handshake
  wire mem_state = (state_reg == ST_PUSH_F) || (state_reg == ST_PUSH_CS) || (state_reg == ST_PUSH_IP) ||
                   (state_reg == ST_RD_IP) || (state_reg == ST_RD_CS);
  wire mem_issue = mem_state && !mem_req_reg;
  wire mem_fin = mem_state && mem_req_reg && mem_done;
  wire is_push = (state_reg == ST_PUSH_F) || (state_reg == ST_PUSH_CS) || (state_reg == ST_PUSH_IP);

  // Stack address after the decrement
  wire [15:0] sp_dec = stack_ptr_reg - `CIE_PUSH_STEP;
  wire [19:0] push_addr = {ss_reg, 4'h0} + {4'h0, sp_dec};
  wire [19:0] entry_addr = {10'h000, vec_reg, 2'b00};
  // IP low word, CS high word
  wire [19:0] rd_addr = (state_reg == ST_RD_CS) ? (entry_addr + `CIE_VEC_CS_OFS) : entry_addr;
  wire [15:0] push_data = (state_reg == ST_PUSH_F) ? flags_reg :
                          (state_reg == ST_PUSH_CS) ? code_seg_reg : instr_pointer_reg;

  // Two acknowledge cycles back to back
  assign ack_start = ((state_reg == ST_ACK1) || (state_reg == ST_ACK2)) && (ts == TS_IDLE);
  wire ack_last = (ts == TS_T4);

  // Entry end once the class length is reached
  wire finish_now = (state_reg == ST_FINISH) && (cyc_reg >= target_reg);

  // Register decode
  wire ctrl_hit = (reg_addr == `CIE_REG_CTRL);
  wire stat_hit = (reg_addr == `CIE_REG_STATUS);
  wire [31:0] ctrl_val = {31'h0000_0000, max_mode_reg};
  wire [31:0] stat_val = {16'h0000, vec_reg, 5'h00, irq_sync, nmi_pend_reg, busy_reg};
  wire [31:0] rd_val = ctrl_hit ? ctrl_val : (stat_hit ? stat_val : 32'h0000_0000);

  // Acknowledge cycle engine instance
  cie_ack_cycle u_ack (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .start(ack_start),
    .tstate(ts),
    .ack(ack_pulse)
  );

  // Sequencer next state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        // Maskable goes through the bus handshake first
        if (take_mask) begin
          state_next = ST_ACK1;
        end else if (take_any) begin
          state_next = ST_PUSH_F;
        end
      end
      // Handshake states leave at T4
      ST_ACK1: state_next = ack_last ? ST_ACK2 : ST_ACK1;
      ST_ACK2: state_next = ack_last ? ST_PUSH_F : ST_ACK2;
      // Memory states advance on completion
      ST_PUSH_F: state_next = mem_fin ? ST_PUSH_CS : ST_PUSH_F;
      ST_PUSH_CS: state_next = mem_fin ? ST_PUSH_IP : ST_PUSH_CS;
      ST_PUSH_IP: state_next = mem_fin ? ST_RD_IP : ST_PUSH_IP;
      ST_RD_IP: state_next = mem_fin ? ST_RD_CS : ST_RD_IP;
      ST_RD_CS: state_next = mem_fin ? ST_FINISH : ST_RD_CS;
      // Wait out the class length
      ST_FINISH: state_next = finish_now ? ST_IDLE : ST_FINISH;
      default: state_next = ST_IDLE;
    endcase
  end

  // Handshake sequence running next cycle
  wire ack_seq_next = (state_next == ST_ACK1) || (state_next == ST_ACK2);

  // Pin synchronisers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= 11'h000;
      sync2_reg <= 11'h000;
    end else begin
      sync1_reg <= {ad_in[7:0], hold_req_pin, maskable_request_in, nmi_pin};
      sync2_reg <= sync1_reg;
    end
  end

  // NMI edge latch
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      nmi_prev_reg <= 1'b0;
      nmi_pend_reg <= 1'b0;
    end else begin
      nmi_prev_reg <= nmi_sync;
      if (nmi_rise) begin
        nmi_pend_reg <= 1'b1;
      end else if (take_nmi) begin
        nmi_pend_reg <= 1'b0;
      end
    end
  end

  // Control register and read data
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      max_mode_reg <= `CIE_CTRL_RST;
      rdata_reg <= 32'h0000_0000;
    end else begin
      if (reg_wr && ctrl_hit) begin
        max_mode_reg <= reg_wdata[`CIE_CTRL_MAXMODE_BIT];
      end
      rdata_reg <= reg_rd ? rd_val : 32'h0000_0000;
    end
  end

  // Sequencer, counters and captured context
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      cyc_reg <= 7'h00;
      target_reg <= 7'h00;
      vec_reg <= 8'h00;
      ss_reg <= 16'h0000;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      done_reg <= finish_now;
      busy_reg <= (state_next != ST_IDLE);
      // Count clocks from recognition
      if (take_any) begin
        cyc_reg <= 7'h01;
        target_reg <= take_clk - 7'h01;
        vec_reg <= take_vec;
        ss_reg <= ss_in;
      end else if (!idle) begin
        cyc_reg <= cyc_reg + 7'h01;
      end
      // Vector byte at T4 of second cycle
      if ((state_reg == ST_ACK2) && ack_last) begin
        vec_reg <= ad_sync;
      end
    end
  end

  // Flags, CS, IP and stack pointer
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_reg <= `CIE_FLAGS_RST;
      code_seg_reg <= 16'h0000;
      instr_pointer_reg <= 16'h0000;
      stack_ptr_reg <= 16'h0000;
    end else begin
      // Core updates in any state
      if (flags_load) begin
        flags_reg <= flags_in;
      end
      if (clear_irq_enable_instr) begin
        flags_reg[`CIE_FLAG_IF_BIT] <= 1'b0;
      end
      // Any entry clears IF and TF
      if ((state_reg == ST_PUSH_F) && mem_fin) begin
        flags_reg[`CIE_FLAG_IF_BIT] <= 1'b0;
        flags_reg[`CIE_FLAG_TF_BIT] <= 1'b0;
      end
      // Capture return linkage
      if (take_any) begin
        code_seg_reg <= cs_in;
        instr_pointer_reg <= ip_in;
        stack_ptr_reg <= sp_in;
      end
      // Each push lowers SP by two
      if (mem_issue && is_push) begin
        stack_ptr_reg <= sp_dec;
      end
      if ((state_reg == ST_RD_IP) && mem_fin) begin
        instr_pointer_reg <= mem_rdata;
      end
      if ((state_reg == ST_RD_CS) && mem_fin) begin
        code_seg_reg <= mem_rdata;
      end
    end
  end

  // Memory request port
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_req_reg <= 1'b0;
      mem_we_reg <= 1'b0;
      mem_addr_reg <= 20'h0_0000;
      mem_wdata_reg <= 16'h0000;
    end else begin
      if (mem_issue) begin
        mem_req_reg <= 1'b1;
        mem_we_reg <= is_push;
        mem_addr_reg <= is_push ? push_addr : rd_addr;
        mem_wdata_reg <= is_push ? push_data : 16'h0000;
      end else if (mem_fin) begin
        mem_req_reg <= 1'b0;
        mem_we_reg <= 1'b0;
      end
    end
  end

  // Bus float, lock and hold arbitration
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      float_reg <= 1'b0;
      lock_reg <= 1'b0;
      hold_ack_reg <= 1'b0;
    end else begin
      float_reg <= ack_seq_next;
      // Lock from first T2 to second T2
      if (max_mode_reg && (state_reg == ST_ACK1) && (ts == TS_T1)) begin
        lock_reg <= 1'b1;
      end else if ((state_reg == ST_ACK2) && (ts == TS_T1)) begin
        lock_reg <= 1'b0;
      end
      hold_ack_reg <= !max_mode_reg && hold_sync && !ack_seq_next;
    end
  end

  // Outputs straight from flops
  assign reg_rdata = rdata_reg;
  assign entry_busy = busy_reg;
  assign entry_done = done_reg;
  assign flags_out = flags_reg;
  assign new_cs = code_seg_reg;
  assign new_ip = instr_pointer_reg;
  assign new_sp = stack_ptr_reg;
  assign irq_acknowledge_out = ack_pulse;
  assign ad_float = float_reg;
  assign bus_lock = lock_reg;
  assign hold_ack = hold_ack_reg;
  assign mem_req = mem_req_reg;
  assign mem_we = mem_we_reg;
  assign mem_addr = mem_addr_reg;
  assign mem_wdata = mem_wdata_reg;
endmodule

//--- src/cie_map.svh
// Summary of operation
// - Vector table: 256 entries at 0..3FFH
// - Entry holds two words loaded into CS/IP
// - Rising edge of async request raises NMI
// - NMI taken after instruction, vector 2
// - NMI pushes flags, clears IF/TF, loads vector
// - Maskable ignored when IF clear; CLEAR_IRQ_ENABLE_INSTR clears
// - Maskable request level, synchronised on clock
// - Maskable entry runs two acknowledge cycles
// - First cycle floats bus, acknowledge T2-T4
// - Minimum mode: no hold until sequence ends
// - Maximum mode: lock T2 first to T2 second
// - Vector byte times four gives entry offset
// - Push flags, clear IF/TF, push CS, IP
// - Priority: software, NMI, then maskable/step
// - Any entry disables maskable and step
// - Entry lasts 61/50/51/52/53 clocks per class
// - Only at boundaries; saves CS, IP, flags
`ifndef CIE_MAP_SVH
`define CIE_MAP_SVH

// Vector table bounds and fixed vectors
`define CIE_VEC_TABLE_LAST 20'h0_03ff
`define CIE_VEC_STEP 8'h01
`define CIE_VEC_NMI 8'h02
`define CIE_VEC_BRK 8'h03
`define CIE_VEC_OVF 8'h04
// Offset of code segment word inside an entry
`define CIE_VEC_CS_OFS 20'h0_0002

// Flag bit positions and reset value
`define CIE_FLAG_TF_BIT 8
`define CIE_FLAG_IF_BIT 9
`define CIE_FLAGS_RST 16'h0002

// Stack step per push
`define CIE_PUSH_STEP 16'h0002

// Processing clocks per class, counted from recognition
`define CIE_CLK_MASKABLE 7'h3d
`define CIE_CLK_NMI 7'h32
`define CIE_CLK_STEP 7'h32
`define CIE_CLK_SW_VEC 7'h33
`define CIE_CLK_SW_BRK 7'h34
`define CIE_CLK_SW_OVF 7'h35

// Register port map
`define CIE_REG_CTRL 4'h0
`define CIE_REG_STATUS 4'h4
`define CIE_CTRL_MAXMODE_BIT 0
`define CIE_CTRL_RST 1'h0
`define CIE_STAT_BUSY_BIT 0
`define CIE_STAT_NMIPEND_BIT 1
`define CIE_STAT_IRQLVL_BIT 2
`define CIE_STAT_VEC_LSB 8

`endif

//--- src/cie_pkg.sv
package cie_pkg;

  // Entry sequencer states
  typedef enum logic [8:0] {
    ST_IDLE    = 9'b0_0000_0001,
    ST_ACK1    = 9'b0_0000_0010,
    ST_ACK2    = 9'b0_0000_0100,
    ST_PUSH_F  = 9'b0_0000_1000,
    ST_PUSH_CS = 9'b0_0001_0000,
    ST_PUSH_IP = 9'b0_0010_0000,
    ST_RD_IP   = 9'b0_0100_0000,
    ST_RD_CS   = 9'b0_1000_0000,
    ST_FINISH  = 9'b1_0000_0000
  } cie_state_e;

  // Acknowledge bus cycle T-states
  typedef enum logic [4:0] {
    TS_IDLE = 5'b0_0001,
    TS_T1   = 5'b0_0010,
    TS_T2   = 5'b0_0100,
    TS_T3   = 5'b0_1000,
    TS_T4   = 5'b1_0000
  } cie_tstate_e;

  // Kind of software interrupt reported by the core
  typedef enum logic [1:0] {
    SW_VECTOR   = 2'h0,
    SW_BREAK    = 2'h1,
    SW_OVERFLOW = 2'h2
  } cie_sw_e;

endpackage

//--- src/cie_ack_cycle.sv
`timescale 1ns/10ps
module cie_ack_cycle (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Control
  input wire logic start,
  // Cycle state
  output cie_pkg::cie_tstate_e tstate,
  output logic ack
);
  import cie_pkg::*;

  // Current T-state and registered acknowledge
  cie_tstate_e ts_reg;
  cie_tstate_e ts_next;
  logic ack_reg;
  logic ack_next;

  // T-state walk T1..T4, then idle
  always_comb begin
    unique case (ts_reg)
      TS_IDLE: ts_next = start ? TS_T1 : TS_IDLE;
      TS_T1: ts_next = TS_T2;
      TS_T2: ts_next = TS_T3;
      TS_T3: ts_next = TS_T4;
      TS_T4: ts_next = TS_IDLE;
      default: ts_next = TS_IDLE;
    endcase
  end

  assign ack_next = (ts_next == TS_T2) || (ts_next == TS_T3) || (ts_next == TS_T4);

  // State and acknowledge flops
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ts_reg <= TS_IDLE;
      ack_reg <= 1'b0;
    end else begin
      ts_reg <= ts_next;
      ack_reg <= ack_next;
    end
  end

  assign tstate = ts_reg;
  assign ack = ack_reg;
endmodule

//--- sim/cie_pic_model.sv
`timescale 1ns/10ps
module cie_pic_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Acknowledge in, vector out
  input wire logic irq_acknowledge_out,
  input wire logic [7:0] vec_type,
  output logic [15:0] ad_in
);
  // High from the end of the first acknowledge to the end of the second
  logic second_reg;
  // Acknowledge one cycle back
  logic ack_d_reg;
  // Filler while the bus is not ours
  logic [15:0] junk_reg;

  // Count acknowledge pulses, shuffle filler
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      second_reg <= 1'b0;
      ack_d_reg <= 1'b0;
      junk_reg <= 16'ha5c3;
    end else begin
      ack_d_reg <= irq_acknowledge_out;
      junk_reg <= {junk_reg[14:0], ~junk_reg[15]};
      // End of a pulse flips the phase
      if (ack_d_reg && !irq_acknowledge_out) begin
        second_reg <= ~second_reg;
      end
    end
  end

  assign ad_in = (irq_acknowledge_out && second_reg) ? {junk_reg[15:8], vec_type} : junk_reg;
endmodule

//--- sim/cie_entry_properties.sv
`timescale 1ns/10ps
module cie_entry_properties (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Watched ports
  input wire logic clear_irq_enable_instr,
  input wire logic entry_busy,
  input wire logic entry_done,
  input wire logic [15:0] flags_out,
  input wire logic irq_acknowledge_out,
  input wire logic ad_float,
  input wire logic bus_lock,
  input wire logic hold_ack,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [19:0] mem_addr
);
  // Cycles spent busy in this entry
  logic [7:0] busy_cnt;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // Busy span counter
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_cnt <= 8'h00;
    end else begin
      busy_cnt <= entry_busy ? busy_cnt + 8'h01 : 8'h00;
    end
  end

  AST_ACK_FLOATS: assert property (irq_acknowledge_out |-> ad_float)
    else $error("acknowledge seen with bus not floated");
  AST_ACK_PULSE: assert property ($rose(irq_acknowledge_out) |->
    irq_acknowledge_out[*3] ##1 !irq_acknowledge_out)
    else $error("acknowledge pulse not three cycles");
  AST_TWO_ACKS: assert property ($rose(ad_float) |-> ##2 irq_acknowledge_out[*3]
    ##1 !irq_acknowledge_out[*2] ##1 irq_acknowledge_out[*3] ##1 !irq_acknowledge_out)
    else $error("acknowledge cycles out of order");
  AST_FLOAT_SPAN: assert property ($rose(ad_float) |=> ##8 ad_float ##1 !ad_float)
    else $error("bus float span wrong");
  AST_LOCK_SPAN: assert property ($rose(bus_lock) |->
    $rose(irq_acknowledge_out) ##0 bus_lock[*5] ##1 !bus_lock)
    else $error("lock span wrong");
  AST_LOCK_FLOAT: assert property (bus_lock |-> ad_float)
    else $error("lock outside acknowledge sequence");
  AST_HOLD_OFF: assert property ($rose(hold_ack) |-> !ad_float)
    else $error("hold granted during acknowledge");
  AST_MIN_TIME: assert property (entry_done |-> busy_cnt >= 8'h30)
    else $error("entry finished too early");
  AST_DONE_PULSE: assert property (entry_done |=> !entry_done)
    else $error("done longer than one cycle");
  AST_FLAGS_CLEARED: assert property (entry_done |-> flags_out[9:8] == 2'b00)
    else $error("flags not cleared at entry");
  AST_VEC_IN_TABLE: assert property (mem_req && !mem_we |-> mem_addr <= 20'h0_03ff)
    else $error("vector read outside table");
  AST_CLI: assert property (clear_irq_enable_instr |=> !flags_out[9])
    else $error("enable flag not cleared");

  // Main scenarios reached
  COV_LOCK: cover property ($rose(bus_lock));
  COV_ACK: cover property ($rose(irq_acknowledge_out));
  COV_DONE: cover property (entry_done);
endmodule

bind cie_entry cie_entry_properties u_props (.core_clk, .rst_n, .clear_irq_enable_instr, .entry_busy,
  .entry_done, .flags_out, .irq_acknowledge_out, .ad_float, .bus_lock, .hold_ack, .mem_req, .mem_we, .mem_addr);

//--- sim/testbench.sv
`timescale 1ns/10ps
module testbench;
  import cie_pkg::*;
  // Clock, reset, register port
  logic core_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, d;
  // Core side
  logic instr_boundary = 1'b0, clear_irq_enable_instr = 1'b0, flags_load = 1'b0, sw_int_req = 1'b0;
  logic [15:0] flags_in = 16'h0002, cs_in = 16'h0000, ip_in = 16'h0000, ss_in = 16'h0000, sp_in = 16'h0000;
  cie_sw_e sw_int_kind = SW_VECTOR;
  logic [7:0] sw_int_type = 8'h00;
  logic entry_busy, entry_done;
  logic [15:0] flags_out, new_cs, new_ip, new_sp;
  // Pins and memory
  logic nmi_pin = 1'b0, maskable_request_in = 1'b0, hold_req_pin = 1'b0;
  logic irq_acknowledge_out, ad_float, bus_lock, hold_ack, mem_req, mem_we, mem_done = 1'b0;
  logic [15:0] ad_in, mem_wdata, mem_rdata;
  logic [19:0] mem_addr;
  // Bench state
  logic [7:0] pic_vec = 8'h41;
  logic served = 1'b0, hold_mode = 1'b0, lock_seen = 1'b0, hold_seen = 1'b0;
  logic [35:0] wq[$];
  int n_fail = 0;
  int samples_checked = 0;

  cie_entry dut (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .instr_boundary,
    .clear_irq_enable_instr, .flags_load, .flags_in, .sw_int_req, .sw_int_kind, .sw_int_type, .cs_in, .ip_in,
    .ss_in, .sp_in, .entry_busy, .entry_done, .flags_out, .new_cs, .new_ip, .new_sp, .nmi_pin,
    .maskable_request_in, .hold_req_pin, .ad_in, .irq_acknowledge_out, .ad_float, .bus_lock, .hold_ack,
    .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_done);
  cie_pic_model u_pic (.core_clk, .rst_n, .irq_acknowledge_out, .vec_type(pic_vec), .ad_in);

  // Free-running clock
  always #2 core_clk = ~core_clk;
  // Table words encode their own address
  assign mem_rdata = {mem_addr[1] ? 8'hc5 : 8'h1a, mem_addr[9:2]};
  // One completion per request, writes logged
  always @(posedge core_clk) begin
    mem_done <= mem_req && !served;
    served <= mem_req;
    if (mem_req && !served && mem_we) begin
      wq.push_back({mem_addr, mem_wdata});
    end
    if (bus_lock) begin
      lock_seen <= 1'b1;
    end
    if (hold_ack) begin
      hold_seen <= 1'b1;
    end
  end
  // Other master lets go once the bus returns
  always @(negedge ad_float) hold_req_pin <= 1'b0;

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a, output logic [31:0] v);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  // Load flags, end an instruction, follow the entry
  task automatic take(input logic sw, input cie_sw_e kind, input logic [15:0] fl, input logic [7:0] vec,
    input int clks);
    int n;
    wq.delete();
    @(posedge core_clk);
    flags_load <= 1'b1;
    flags_in <= fl;
    sw_int_req <= sw;
    sw_int_kind <= kind;
    sw_int_type <= vec;
    cs_in <= {8'h3c, vec};
    ip_in <= {8'h7e, vec};
    ss_in <= 16'h0100;
    sp_in <= 16'h0200;
    @(posedge core_clk);
    flags_load <= 1'b0;
    instr_boundary <= 1'b1;
    @(posedge core_clk);
    instr_boundary <= 1'b0;
    sw_int_req <= 1'b0;
    hold_req_pin <= hold_mode;
    // The cycle right after recognition counts as the first
    n = 1;
    do begin
      @(posedge core_clk);
      #1 n++;
    end while (entry_done !== 1'b1 && n < 400);
    cmp("entry_done", 1, entry_done);
    if (clks > 0) cmp("cycles", clks, n);
    cmp("new_ip", {8'h1a, vec}, new_ip);
    cmp("new_cs", {8'hc5, vec}, new_cs);
    cmp("new_sp", 16'h01fa, new_sp);
    cmp("pushes", 3, wq.size());
    for (int i = 0; i < wq.size() && i < 3; i++) begin
      cmp("push_addr", 20'h0_1200 - 20'(2 * (i + 1)), wq[i][35:16]);
      cmp("push_data", i == 0 ? fl : (i == 1 ? {8'h3c, vec} : {8'h7e, vec}), wq[i][15:0]);
    end
  endtask

  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    reg_write(4'h8, 32'hffff_ffff);
    reg_read(4'h8, d);
    cmp("unmapped", 0, d);
    reg_write(4'h0, 32'h0000_0001);
    reg_read(4'h0, d);
    cmp("ctrl", 1, d);
    @(posedge core_clk);
    maskable_request_in <= 1'b1;
    repeat (4) @(posedge core_clk);
    instr_boundary <= 1'b1;
    @(posedge core_clk);
    instr_boundary <= 1'b0;
    repeat (4) @(posedge core_clk);
    #1 cmp("masked", 0, {ad_float, entry_busy});
    @(posedge core_clk);
    nmi_pin <= 1'b1;
    repeat (3) @(posedge core_clk);
    nmi_pin <= 1'b0;
    lock_seen = 1'b0;
    for (int i = 0; i < 3; i++) begin
      take(1'b1, cie_sw_e'(i), 16'h0202, i == 0 ? 8'h80 : 8'(i + 2), 51 + i);
    end
    take(1'b0, SW_VECTOR, 16'h0202, 8'h02, 50);
    take(1'b0, SW_VECTOR, 16'h0202, 8'h41, 61);
    cmp("lock_max", 1, lock_seen);
    reg_read(4'h4, d);
    cmp("status_vec", 8'h41, d[15:8]);
    @(posedge core_clk);
    maskable_request_in <= 1'b0;
    repeat (3) @(posedge core_clk);
    take(1'b0, SW_VECTOR, 16'h0102, 8'h01, 50);
    @(posedge core_clk);
    flags_load <= 1'b1;
    flags_in <= 16'h0302;
    clear_irq_enable_instr <= 1'b1;
    @(posedge core_clk);
    flags_load <= 1'b0;
    clear_irq_enable_instr <= 1'b0;
    @(posedge core_clk);
    #1 cmp("cli", 16'h0102, flags_out);
    reg_write(4'h0, 32'h0000_0000);
    pic_vec <= 8'h20;
    maskable_request_in <= 1'b1;
    hold_mode = 1'b1;
    lock_seen = 1'b0;
    hold_seen = 1'b0;
    repeat (4) @(posedge core_clk);
    take(1'b0, SW_VECTOR, 16'h0202, 8'h20, 61);
    cmp("lock_min", 0, lock_seen);
    cmp("hold_min", 1, hold_seen);
    tally_and_finish();
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    tally_and_finish();
  end
endmodule
